/* File: hw/idps_pkg.sv */
package idps_pkg;
   // Low offsets within a page and full addresses on page 0
   localparam logic [7:0]  PAGE_SEL_LOW      = 8'h01;
   localparam logic [15:0] SILICON_REV_ADDR  = 16'h0000;
   localparam logic [15:0] PN_LOW_ADDR       = 16'h0002;
   localparam logic [15:0] PN_HIGH_ADDR      = 16'h0003;
   localparam logic [15:0] SPEED_GRADE_ADDR  = 16'h0004;
   localparam logic [15:0] DEV_REV_ADDR      = 16'h0005;
   localparam logic [15:0] TEMP_CLASS_ADDR   = 16'h0009;
   localparam logic [15:0] PKG_CODE_ADDR     = 16'h000A;
   localparam logic [15:0] BUS_ADDR_ADDR     = 16'h000B;
   localparam logic [15:0] DEV_STATUS_ADDR   = 16'h000C;
   localparam logic [15:0] STICKY_ADDR       = 16'h0011;
   localparam logic [15:0] CONFIG_ADDR       = 16'h0020;
   localparam logic [15:0] BURN_ADDR         = 16'h0021;
   // Burn key written to the burn register
   localparam logic [7:0]  BURN_KEY          = 8'hA5;
   // Status bit positions
   localparam int          ST_CAL            = 0;
   localparam int          ST_XTAL_LOST      = 1;
   localparam int          ST_REF_LOST       = 2;
   localparam int          ST_LOCK_ERR       = 3;
   localparam int          ST_BUS_TMO        = 5;
   localparam logic [7:0]  STATUS_MASK       = 8'h2F;
   // Config bit positions
   localparam int          CFG_OUT_EN        = 0;
   localparam int          CFG_IO_1V8        = 1;
   localparam int          CFG_EXT_XO        = 2;
   localparam logic [7:0]  CONFIG_MASK       = 8'h07;
   // Blank variant power-up config: outputs off, 1.8 V I/O, 54 MHz XO
   localparam logic [7:0]  BLANK_CONFIG      = 8'h06;
   localparam logic [7:0]  PAGE_RESET        = 8'h00;
   localparam logic [7:0]  BYTE_ZERO         = 8'h00;
   localparam logic [7:0]  PAGE_ZERO         = 8'h00;
   // Identity values, arbitrary neutral choices
   localparam logic [3:0]  SILICON_REV_VAL   = 4'h1;
   localparam logic [15:0] PART_DIGITS_VAL   = 16'h1234;
   localparam logic [7:0]  SPEED_GRADE_VAL   = 8'h00;
   localparam logic [7:0]  DEV_REV_VAL       = 8'h04;
   localparam logic [7:0]  TEMP_CLASS_VAL    = 8'h00;
   localparam logic [7:0]  PKG_CODE_VAL      = 8'h00;
   localparam logic [4:0]  BUS_ADDR_UPPER    = 5'h1A;

   typedef enum logic [1:0] {IDPS_BOOT, IDPS_LOAD, IDPS_RUN} idps_boot_t;
endpackage : idps_pkg

/* File: hw/idps_regs.sv */
`timescale 1ns/1ps
module idps_regs (
   mclk,
   rstn,
   acc_addr,
   acc_wr,
   acc_rd,
   acc_wdata,
   acc_rdata_q,
   acc_rvalid_q,
   addr_select_pin_hi,
   addr_select_pin_lo,
   calibrating_now,
   crystal_input_lost,
   reference_signal_lost,
   reference_lock_error,
   bus_timeout_now,
   preprogrammed_strap,
   nvm_valid,
   nvm_config,
   cfg_outputs_en_q,
   cfg_io_1v8_q,
   cfg_ext_xo_q,
   nvm_burn_q,
   nvm_burn_data_q,
   page_q
);
   input  wire logic       mclk;
   input  wire logic       rstn;
   input  wire logic [7:0] acc_addr;
   input  wire logic       acc_wr;
   input  wire logic       acc_rd;
   input  wire logic [7:0] acc_wdata;
   output logic      [7:0] acc_rdata_q;
   output logic            acc_rvalid_q;
   input  wire logic       addr_select_pin_hi;
   input  wire logic       addr_select_pin_lo;
   input  wire logic       calibrating_now;
   input  wire logic       crystal_input_lost;
   input  wire logic       reference_signal_lost;
   input  wire logic       reference_lock_error;
   input  wire logic       bus_timeout_now;
   input  wire logic       preprogrammed_strap;
   input  wire logic       nvm_valid;
   input  wire logic [7:0] nvm_config;
   output logic            cfg_outputs_en_q;
   output logic            cfg_io_1v8_q;
   output logic            cfg_ext_xo_q;
   output logic            nvm_burn_q;
   output logic      [7:0] nvm_burn_data_q;
   output logic      [7:0] page_q;

   logic [7:0]           status_q;
   logic [7:0]           sticky_q;
   logic [7:0]           config_q;
   logic [1:0]           pins_q;
   logic [7:0]           rdata_d;
   idps_pkg::idps_boot_t boot_q;
   logic [15:0]          full_addr;
   logic                 page_hit;

   function automatic logic hit(input logic [15:0] a, input logic [15:0] target);
      hit = (a == target);
   endfunction : hit

   assign full_addr = {page_q, acc_addr};
   assign page_hit  = (acc_addr == idps_pkg::PAGE_SEL_LOW);

   // Page select, full 8 bits so every one of 256 pages is reachable
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         page_q <= idps_pkg::PAGE_RESET;
      end else if (acc_wr && page_hit) begin
         page_q <= acc_wdata;
      end
   end

   // Live status, one flop so the bus sees a clean value
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         status_q <= idps_pkg::BYTE_ZERO;
      end else begin
         status_q <= idps_pkg::BYTE_ZERO;
         status_q[idps_pkg::ST_CAL]       <= calibrating_now;
         status_q[idps_pkg::ST_XTAL_LOST] <= crystal_input_lost;
         status_q[idps_pkg::ST_REF_LOST]  <= reference_signal_lost;
         status_q[idps_pkg::ST_LOCK_ERR]  <= reference_lock_error;
         status_q[idps_pkg::ST_BUS_TMO]   <= bus_timeout_now;
      end
   end

   // Sticky flags; a new event beats a clear in the same cycle
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         sticky_q <= idps_pkg::BYTE_ZERO;
      end else begin
         for (int i = 0; i < 8; i++) begin
            if (idps_pkg::STATUS_MASK[i]) begin
               if (status_q[i]) begin
                  sticky_q[i] <= 1'b1;
               end else if (acc_wr && hit(full_addr, idps_pkg::STICKY_ADDR) && !acc_wdata[i]) begin
                  sticky_q[i] <= 1'b0;
               end
            end
         end
      end
   end

   // Address pins sampled every cycle
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         pins_q <= 2'h0;
      end else begin
         pins_q <= {addr_select_pin_hi, addr_select_pin_lo};
      end
   end

   // Boot: blank comes up with defaults, preprogrammed waits for NVM image
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         boot_q <= idps_pkg::IDPS_BOOT;
      end else begin
         case (boot_q)
            idps_pkg::IDPS_BOOT: boot_q <= preprogrammed_strap ? idps_pkg::IDPS_LOAD : idps_pkg::IDPS_RUN;
            idps_pkg::IDPS_LOAD: if (nvm_valid) begin
               boot_q <= idps_pkg::IDPS_RUN;
            end
            idps_pkg::IDPS_RUN:  boot_q <= idps_pkg::IDPS_RUN;
            default:             boot_q <= idps_pkg::IDPS_BOOT;
         endcase
      end
   end

   // Host writes are honoured only once boot is done
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         config_q <= idps_pkg::BLANK_CONFIG;
      end else if (boot_q == idps_pkg::IDPS_LOAD && nvm_valid) begin
         config_q <= nvm_config & idps_pkg::CONFIG_MASK;
      end else if (boot_q == idps_pkg::IDPS_RUN && acc_wr && hit(full_addr, idps_pkg::CONFIG_ADDR)) begin
         config_q <= acc_wdata & idps_pkg::CONFIG_MASK;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         cfg_outputs_en_q <= idps_pkg::BLANK_CONFIG[idps_pkg::CFG_OUT_EN];
         cfg_io_1v8_q     <= idps_pkg::BLANK_CONFIG[idps_pkg::CFG_IO_1V8];
         cfg_ext_xo_q     <= idps_pkg::BLANK_CONFIG[idps_pkg::CFG_EXT_XO];
      end else begin
         cfg_outputs_en_q <= config_q[idps_pkg::CFG_OUT_EN];
         cfg_io_1v8_q     <= config_q[idps_pkg::CFG_IO_1V8];
         cfg_ext_xo_q     <= config_q[idps_pkg::CFG_EXT_XO];
      end
   end

   // Burn image carries config only; bus address never goes to NVM
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         nvm_burn_q      <= 1'b0;
         nvm_burn_data_q <= idps_pkg::BYTE_ZERO;
      end else begin
         nvm_burn_q <= acc_wr && hit(full_addr, idps_pkg::BURN_ADDR)
                       && (acc_wdata == idps_pkg::BURN_KEY);
         if (acc_wr && hit(full_addr, idps_pkg::BURN_ADDR) && (acc_wdata == idps_pkg::BURN_KEY)) begin
            nvm_burn_data_q <= config_q;
         end
      end
   end

   always_comb begin
      rdata_d = idps_pkg::BYTE_ZERO;
      if (page_hit) begin
         rdata_d = page_q;
      end else begin
         case (full_addr)
            idps_pkg::SILICON_REV_ADDR: rdata_d = {4'h0, idps_pkg::SILICON_REV_VAL};
            idps_pkg::PN_LOW_ADDR:      rdata_d = idps_pkg::PART_DIGITS_VAL[7:0];
            idps_pkg::PN_HIGH_ADDR:     rdata_d = idps_pkg::PART_DIGITS_VAL[15:8];
            idps_pkg::SPEED_GRADE_ADDR: rdata_d = idps_pkg::SPEED_GRADE_VAL;
            idps_pkg::DEV_REV_ADDR:     rdata_d = idps_pkg::DEV_REV_VAL;
            idps_pkg::TEMP_CLASS_ADDR:  rdata_d = idps_pkg::TEMP_CLASS_VAL;
            idps_pkg::PKG_CODE_ADDR:    rdata_d = idps_pkg::PKG_CODE_VAL;
            idps_pkg::BUS_ADDR_ADDR:    rdata_d = {1'b0, idps_pkg::BUS_ADDR_UPPER, pins_q};
            idps_pkg::DEV_STATUS_ADDR:  rdata_d = status_q & idps_pkg::STATUS_MASK;
            idps_pkg::STICKY_ADDR:      rdata_d = sticky_q;
            idps_pkg::CONFIG_ADDR:      rdata_d = config_q;
            default:                    rdata_d = idps_pkg::BYTE_ZERO;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         acc_rdata_q  <= idps_pkg::BYTE_ZERO;
         acc_rvalid_q <= 1'b0;
      end else begin
         acc_rvalid_q <= acc_rd;
         if (acc_rd) begin
            acc_rdata_q <= rdata_d;
         end
      end
   end

   property p_page_write;
      @(posedge mclk) disable iff (!rstn)
      (acc_wr && acc_addr == idps_pkg::PAGE_SEL_LOW) |=> (page_q == $past(acc_wdata));
   endproperty
   a_page_write: assert property (p_page_write) else $error("page write not taken");

   property p_page_read;
      @(posedge mclk) disable iff (!rstn)
      (acc_rd && !acc_wr && acc_addr == idps_pkg::PAGE_SEL_LOW) |=> (acc_rvalid_q && acc_rdata_q == page_q);
   endproperty
   a_page_read: assert property (p_page_read) else $error("page read wrong on this page");

   property p_status_live;
      @(posedge mclk) disable iff (!rstn)
      ##1 (status_q[idps_pkg::ST_CAL] == $past(calibrating_now))
          && (status_q[idps_pkg::ST_BUS_TMO] == $past(bus_timeout_now));
   endproperty
   a_status_live: assert property (p_status_live) else $error("status not live");

   sequence s_lock_then_status_read;
      reference_lock_error ##1 (acc_rd && full_addr == idps_pkg::DEV_STATUS_ADDR && !page_hit);
   endsequence

   property p_lock_err;
      @(posedge mclk) disable iff (!rstn)
      s_lock_then_status_read |=> acc_rdata_q[idps_pkg::ST_LOCK_ERR];
   endproperty
   a_lock_err: assert property (p_lock_err) else $error("lock error bit missing");

   property p_status_zero_bits;
      @(posedge mclk) disable iff (!rstn)
      (acc_rd && full_addr == idps_pkg::DEV_STATUS_ADDR && !page_hit) |=> (acc_rdata_q[4] == 1'b0)
         && (acc_rdata_q[7:6] == 2'h0);
   endproperty
   a_status_zero_bits: assert property (p_status_zero_bits) else $error("reserved status bit set");

   property p_sticky_hold;
      @(posedge mclk) disable iff (!rstn)
      status_q[idps_pkg::ST_XTAL_LOST] |=> sticky_q[idps_pkg::ST_XTAL_LOST];
   endproperty
   a_sticky_hold: assert property (p_sticky_hold) else $error("sticky flag not set");

   property p_sticky_clear;
      @(posedge mclk) disable iff (!rstn)
      (acc_wr && full_addr == idps_pkg::STICKY_ADDR && !page_hit && !acc_wdata[0] && !status_q[0])
         |=> !sticky_q[0];
   endproperty
   a_sticky_clear: assert property (p_sticky_clear) else $error("sticky flag not cleared");

   property p_bus_addr_pins;
      @(posedge mclk) disable iff (!rstn)
      (acc_rd && full_addr == idps_pkg::BUS_ADDR_ADDR && !page_hit) |=> (acc_rdata_q[1:0] == $past(pins_q));
   endproperty
   a_bus_addr_pins: assert property (p_bus_addr_pins) else $error("address pins not reflected");

   property p_blank_boot;
      @(posedge mclk)
      (!rstn ##1 rstn && !preprogrammed_strap) |-> ##2 (!cfg_outputs_en_q && cfg_io_1v8_q && cfg_ext_xo_q);
   endproperty
   a_blank_boot: assert property (p_blank_boot) else $error("blank defaults wrong");

   property p_burn_image;
      @(posedge mclk) disable iff (!rstn)
      (acc_wr && full_addr == idps_pkg::BURN_ADDR && !page_hit && acc_wdata == idps_pkg::BURN_KEY)
         |=> (nvm_burn_q && nvm_burn_data_q == $past(config_q));
   endproperty
   a_burn_image: assert property (p_burn_image) else $error("burn image wrong");

   property p_sticky_set_wins;
      @(posedge mclk) disable iff (!rstn)
      (status_q[idps_pkg::ST_CAL] && acc_wr && full_addr == idps_pkg::STICKY_ADDR && !acc_wdata[idps_pkg::ST_CAL])
         |=> sticky_q[idps_pkg::ST_CAL];
   endproperty
   a_sticky_set_wins: assert property (p_sticky_set_wins) else $error("sticky clear beat a live event");

   property p_nvm_load;
      @(posedge mclk) disable iff (!rstn)
      (boot_q == idps_pkg::IDPS_LOAD && nvm_valid) |=> (config_q == ($past(nvm_config) & idps_pkg::CONFIG_MASK));
   endproperty
   a_nvm_load: assert property (p_nvm_load) else $error("stored image not loaded");

   property p_read_answer;
      @(posedge mclk) disable iff (!rstn)
      ##1 (acc_rvalid_q == $past(acc_rd));
   endproperty
   a_read_answer: assert property (p_read_answer) else $error("read answer not one cycle after strobe");

endmodule : idps_regs

/* File: verification/idps_nvm_model.sv */
`timescale 1ns/1ps
// Non-volatile store beside the register block; keeps its image through reset
module idps_nvm_model (
   input  wire logic       mclk,
   input  wire logic       nvm_burn_q,
   input  wire logic [7:0] nvm_burn_data_q,
   output logic            nvm_valid,
   output logic      [7:0] nvm_config
);
   logic [7:0] image_q = 8'h00;

   // Image always readable, so the loader never stalls
   assign nvm_valid  = 1'b1;
   assign nvm_config = image_q;

   always_ff @(posedge mclk) begin
      if (nvm_burn_q) begin
         image_q <= nvm_burn_data_q;
      end
   end
endmodule : idps_nvm_model

/* File: verification/testbench.sv */
`timescale 1ns/1ps
module testbench;
   logic       mclk;
   logic       rstn;
   logic [7:0] acc_addr;
   logic       acc_wr;
   logic       acc_rd;
   logic [7:0] acc_wdata;
   logic [7:0] acc_rdata_q;
   logic       acc_rvalid_q;
   logic       pin_hi;
   logic       pin_lo;
   logic [4:0] live;
   logic       strap;
   logic       nvm_valid;
   logic [7:0] nvm_config;
   logic       out_en;
   logic       io_1v8;
   logic       ext_xo;
   logic       burn;
   logic [7:0] burn_data;
   logic [7:0] page_q;
   int         errors;
   int         cmp_count;
   int         cycles;
   logic [7:0] st_exp [5] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h20};

   idps_regs dut (.mclk(mclk), .rstn(rstn), .acc_addr(acc_addr), .acc_wr(acc_wr), .acc_rd(acc_rd),
      .acc_wdata(acc_wdata), .acc_rdata_q(acc_rdata_q), .acc_rvalid_q(acc_rvalid_q),
      .addr_select_pin_hi(pin_hi), .addr_select_pin_lo(pin_lo), .calibrating_now(live[0]),
      .crystal_input_lost(live[1]), .reference_signal_lost(live[2]), .reference_lock_error(live[3]),
      .bus_timeout_now(live[4]), .preprogrammed_strap(strap), .nvm_valid(nvm_valid),
      .nvm_config(nvm_config), .cfg_outputs_en_q(out_en), .cfg_io_1v8_q(io_1v8), .cfg_ext_xo_q(ext_xo),
      .nvm_burn_q(burn), .nvm_burn_data_q(burn_data), .page_q(page_q));

   idps_nvm_model nvm (.mclk(mclk), .nvm_burn_q(burn), .nvm_burn_data_q(burn_data),
      .nvm_valid(nvm_valid), .nvm_config(nvm_config));

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   task automatic end_of_test();
      $display("Comparisons %0d, errors %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_of_test

   // Generous ceiling; the sequence needs about a hundred cycles
   always @(posedge mclk) begin
      cycles++;
      if (cycles >= 2000) begin
         errors++;
         end_of_test();
      end
   end

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      acc_addr  = a;
      acc_wdata = d;
      acc_wr    = 1'b1;
      @(negedge mclk);
      acc_wr    = 1'b0;
   endtask : wr

   // Answer is registered: valid in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
      @(negedge mclk);
      acc_addr = a;
      acc_rd   = 1'b1;
      @(negedge mclk);
      acc_rd   = 1'b0;
      chk({what, " valid"}, 8'h01, {7'h00, acc_rvalid_q});
      chk(what, exp, acc_rdata_q);
   endtask : rd

   task automatic cfg(input logic [2:0] exp);
      chk("config", {5'h00, exp}, {5'h00, ext_xo, io_1v8, out_en});
   endtask : cfg

   task automatic do_reset();
      rstn = 1'b0;
      repeat (5) @(negedge mclk);
      rstn = 1'b1;
      repeat (4) @(negedge mclk);
   endtask : do_reset

   initial begin
      {acc_addr, acc_wr, acc_rd, acc_wdata, pin_hi, pin_lo, live, strap} = '0;
      {errors, cmp_count, cycles} = '0;
      rstn = 1'b0;
      do_reset();
      cfg(3'h6);
      chk("page", idps_pkg::PAGE_RESET, page_q);
      rd(8'h00, {4'h0, idps_pkg::SILICON_REV_VAL}, "die revision");
      rd(8'h02, idps_pkg::PART_DIGITS_VAL[7:0], "part low");
      rd(8'h03, idps_pkg::PART_DIGITS_VAL[15:8], "part high");
      wr(8'h04, 8'hFF);
      rd(8'h04, idps_pkg::SPEED_GRADE_VAL, "grade");
      wr(8'h05, 8'hFF);
      rd(8'h05, idps_pkg::DEV_REV_VAL, "dev rev");
      rd(8'h09, idps_pkg::TEMP_CLASS_VAL, "temp");
      rd(8'h0A, idps_pkg::PKG_CODE_VAL, "package");
      for (int i = 0; i < 4; i++) begin
         {pin_hi, pin_lo} = i[1:0];
         wr(8'h0B, 8'h00);
         rd(8'h0B, {1'b0, idps_pkg::BUS_ADDR_UPPER, i[1:0]}, "bus addr");
      end
      for (int i = 0; i < 5; i++) begin
         live = 5'h01 << i;
         @(negedge mclk);
         rd(8'h0C, st_exp[i], "status");
      end
      live = 5'h1F;
      @(negedge mclk);
      rd(8'h0C, idps_pkg::STATUS_MASK, "status all");
      live = 5'h01;
      repeat (2) @(negedge mclk);
      wr(8'h11, 8'h00);
      rd(8'h11, 8'h01, "sticky held");
      live = 5'h00;
      repeat (2) @(negedge mclk);
      wr(8'h11, 8'h00);
      rd(8'h11, 8'h00, "sticky clear");
      wr(8'h01, 8'h02);
      rd(8'h01, 8'h02, "page mirror");
      wr(8'h01, 8'hFF);
      chk("page top", 8'hFF, page_q);
      rd(8'h00, 8'h00, "off page");
      wr(8'h01, 8'h00);
      wr(8'h20, 8'h01);
      @(negedge mclk);
      cfg(3'h1);
      rd(8'h20, 8'h01, "config read");
      wr(8'h21, 8'h5A);
      chk("wrong key", 8'h00, {7'h00, burn});
      wr(8'h21, idps_pkg::BURN_KEY);
      chk("burn", 8'h01, {7'h00, burn});
      chk("burn data", 8'h01, burn_data);
      @(negedge mclk);
      strap = 1'b1;
      do_reset();
      cfg(3'h1);
      end_of_test();
   end
endmodule : testbench
